/* src/genset_mode_sequencer.sv */
// Behaviour
// - Entering halt clears latched alarms whose condition has gone; others stay.
// - Halt with engine running opens generator breaker, then closes utility.
// - Halt removes fuel so a running engine stops.
// - In halt every start request is ignored.
// - Hand-mode start press starts the engine and runs it off load.
// - Load-to-genset press syncs to a live utility, then closes generator.
// - Load-to-utility press ramps generator load down, then opens generator.
// - On-load input rising while running unloaded syncs, then closes generator.
// - On-load input falling ramps load off, then opens generator breaker.
// - Load-to-utility press closes utility breaker, syncing first when needed.
// - Digital inputs request the same transfers as the two load buttons.
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ns

module genset_mode_sequencer
    import genset_pkg::*;
#(
    parameter int ALARM_W = 8
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire button_t button,
    input wire logic din_to_genset,
    input wire logic din_to_utility,
    input wire logic on_load_in,
    input wire logic engine_running,
    input wire logic in_sync,
    input wire logic ramp_done,
    input wire logic [ALARM_W-1:0] alarm_cond,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output plant_t plant,
    output logic irq
);

    localparam int EW = `GS_EVT_W;

    // Edge detection of buttons, digital inputs and the on-load input.
    logic [7:0] lvl_rise;
    logic [7:0] lvl_fall;
    button_t press;
    logic din_gen_rise;
    logic din_util_rise;
    logic onload_rise;
    logic onload_fall;

    edge_detect #(
        .W(8)
    ) u_edges (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .level({on_load_in, din_to_utility, din_to_genset, button}),
        .rise(lvl_rise),
        .fall(lvl_fall)
    );

    assign press = ce ? button_t'(lvl_rise[4:0]) : '0;
    assign din_gen_rise = ce & lvl_rise[5];
    assign din_util_rise = ce & lvl_rise[6];
    assign onload_rise = ce & lvl_rise[7];
    assign onload_fall = ce & lvl_fall[7];

    // Register state.
    mode_t mode;
    mode_t next_mode;
    seq_t seq;
    seq_t next_seq;
    plant_t next_plant;
    logic pend_util;
    logic next_pend_util;
    logic [`GS_CTRL_W-1:0] ctrl;
    logic [`GS_CTRL_W-1:0] next_ctrl;
    logic [EW-1:0] mask;
    logic [EW-1:0] next_mask;
    logic [EW-1:0] status;
    logic [EW-1:0] next_status;
    logic [EW-1:0] evt;
    logic [31:0] next_readdata;
    logic next_waitrequest;
    logic next_irq;
    logic halt_sel;
    logic to_gen_req;
    logic to_util_req;
    logic [ALARM_W-1:0] alarm_latched;
    logic [ALARM_W-1:0] alarm_fresh;

    // A halt press re-arms the stale alarm clear even if already halted.
    assign halt_sel = press.halt;

    alarm_latch #(
        .W(ALARM_W)
    ) u_alarms (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .cond(alarm_cond),
        .clear_stale(halt_sel),
        .latched(alarm_latched),
        .fresh(alarm_fresh)
    );

    // Transfer requests merge buttons with the enabled digital inputs.
    always_comb begin
        to_gen_req = press.load_to_genset_button
            | (ctrl[`GS_CTRL_DIN_EN] & din_gen_rise);
        to_util_req = press.load_to_utility_button
            | (ctrl[`GS_CTRL_DIN_EN] & din_util_rise);
    end

    // Mode selection; halt wins if both mode buttons rise together.
    always_comb begin
        next_mode = mode;
        next_pend_util = pend_util;
        if (press.halt) begin
            next_mode = MODE_HALT;
            next_pend_util = pend_util | engine_running;
        end else if (press.hand) begin
            next_mode = MODE_HAND;
            next_pend_util = 1'b0;
        end else if (plant.util_close) begin
            next_pend_util = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mode <= MODE_HALT;
            pend_util <= 1'b0;
        end else begin
            mode <= next_mode;
            pend_util <= next_pend_util;
        end
    end

    // Sequencer. Breaker commands change one step at a time so on halt the
    // generator breaker is open before the utility one closes.
    always_comb begin
        next_seq = seq;
        next_plant = plant;
        if (mode == MODE_HALT || halt_sel) begin
            next_seq = SEQ_IDLE;
            next_plant.fuel = 1'b0;
            next_plant.crank = 1'b0;
            next_plant.sync = 1'b0;
            next_plant.ramp = 1'b0;
            if (plant.gen_close) begin
                next_plant.gen_close = 1'b0;
            end else if (pend_util) begin
                next_plant.util_close = 1'b1;
            end
        end else if (press.hand) begin
            // Re-selecting the mode drops any transfer in progress.
            next_plant.sync = 1'b0;
            next_plant.ramp = 1'b0;
            if (seq == SEQ_SYNC) begin
                next_seq = SEQ_RUN_OFF;
            end else if (seq == SEQ_USYNC || seq == SEQ_RAMP) begin
                next_seq = SEQ_ON_LOAD;
            end
        end else begin
            unique case (seq)
                SEQ_IDLE: begin
                    if (press.start) begin
                        next_seq = SEQ_CRANK;
                        next_plant.fuel = 1'b1;
                        next_plant.crank = 1'b1;
                    end
                end
                SEQ_CRANK: begin
                    if (engine_running) begin
                        next_seq = SEQ_RUN_OFF;
                        next_plant.crank = 1'b0;
                    end
                end
                SEQ_RUN_OFF: begin
                    if (!engine_running) begin
                        // Engine lost off load: stop fuelling it.
                        next_seq = SEQ_IDLE;
                        next_plant.fuel = 1'b0;
                    end else if (to_gen_req) begin
                        next_seq = SEQ_SYNC;
                        next_plant.sync = 1'b1;
                    end else if (ctrl[`GS_CTRL_ONLOAD_EN] && onload_rise) begin
                        next_seq = SEQ_SYNC;
                        next_plant.sync = 1'b1;
                    end else if (to_util_req) begin
                        // Generator is off the bus, so no sync is needed.
                        next_plant.util_close = 1'b1;
                    end
                end
                SEQ_SYNC: begin
                    // A dead utility bus needs no synchronism.
                    if (in_sync || !plant.util_close) begin
                        next_seq = SEQ_ON_LOAD;
                        next_plant.sync = 1'b0;
                        next_plant.gen_close = 1'b1;
                    end
                end
                SEQ_ON_LOAD: begin
                    if (to_util_req) begin
                        next_seq = SEQ_USYNC;
                        next_plant.sync = 1'b1;
                    end else if (ctrl[`GS_CTRL_ONLOAD_EN] && onload_fall) begin
                        next_seq = SEQ_RAMP;
                        next_plant.ramp = 1'b1;
                    end
                end
                SEQ_USYNC: begin
                    if (plant.util_close || in_sync) begin
                        next_seq = SEQ_RAMP;
                        next_plant.sync = 1'b0;
                        next_plant.util_close = 1'b1;
                        next_plant.ramp = 1'b1;
                    end
                end
                SEQ_RAMP: begin
                    if (ramp_done) begin
                        next_seq = SEQ_RUN_OFF;
                        next_plant.ramp = 1'b0;
                        next_plant.gen_close = 1'b0;
                    end
                end
                default: begin
                    next_seq = SEQ_IDLE;
                    next_plant = '0;
                end
            endcase
        end
        if (!ce) begin
            next_seq = seq;
            next_plant = plant;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            seq <= SEQ_IDLE;
            plant <= '0;
        end else begin
            seq <= next_seq;
            plant <= next_plant;
        end
    end

    // Events raised by this cycle's transitions.
    always_comb begin
        evt = '0;
        if (ce) begin
            evt[`GS_EVT_MODE] = next_mode != mode;
            evt[`GS_EVT_GEN_CLOSED] = next_plant.gen_close & ~plant.gen_close;
            evt[`GS_EVT_GEN_OPENED] = ~next_plant.gen_close & plant.gen_close;
            evt[`GS_EVT_UTIL_CLOSED] = next_plant.util_close
                & ~plant.util_close;
            evt[`GS_EVT_ALARM] = |alarm_fresh;
        end
    end

    // Avalon-MM slave. Waitrequest holds for one cycle per access, the
    // answer stands in the next cycle; the wait also gives read data a
    // full cycle from the decode so outputs stay register driven.
    always_comb begin
        next_waitrequest = avs_waitrequest;
        next_readdata = avs_readdata;
        next_ctrl = ctrl;
        next_mask = mask;
        next_status = status;
        if (ce) begin
            if (avs_waitrequest) begin
                if (avs_read || avs_write) begin
                    next_waitrequest = 1'b0;
                end
                next_readdata = '0;
                if (avs_read) begin
                    unique case (avs_address)
                        `GS_OFF_CTRL: next_readdata[`GS_CTRL_W-1:0] = ctrl;
                        `GS_OFF_STATUS: next_readdata[EW-1:0] = status;
                        `GS_OFF_MASK: next_readdata[EW-1:0] = mask;
                        `GS_OFF_STATE: begin
                            next_readdata[`GS_ST_PEND] = pend_util;
                            next_readdata[`GS_ST_MODE] = mode;
                            next_readdata[`GS_ST_SEQ +: 3] = seq;
                            next_readdata[`GS_ST_PLANT +: 6] = plant;
                        end
                        `GS_OFF_ALARM:
                            next_readdata[ALARM_W-1:0] = alarm_latched;
                        default: next_readdata = '0;
                    endcase
                end
            end else begin
                next_waitrequest = 1'b1;
                if (avs_write && avs_address == `GS_OFF_CTRL) begin
                    next_ctrl = avs_writedata[`GS_CTRL_W-1:0];
                end
                if (avs_write && avs_address == `GS_OFF_MASK) begin
                    next_mask = avs_writedata[EW-1:0];
                end
            end
            // Only the bits actually returned are cleared by the read.
            if (!avs_waitrequest && avs_read
                    && avs_address == `GS_OFF_STATUS) begin
                next_status = sticky_upd(status, evt, avs_readdata[EW-1:0]);
            end else begin
                next_status = sticky_upd(status, evt, '0);
            end
        end
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            ctrl <= `GS_CTRL_RST;
            mask <= `GS_MASK_RST;
            status <= '0;
            irq <= 1'b0;
        end else begin
            avs_waitrequest <= next_waitrequest;
            avs_readdata <= next_readdata;
            ctrl <= next_ctrl;
            mask <= next_mask;
            status <= next_status;
            irq <= next_irq;
        end
    end

endmodule : genset_mode_sequencer

/* src/genset_cfg.svh */
`ifndef GENSET_CFG_SVH
`define GENSET_CFG_SVH

// Register byte offsets on the Avalon-MM slave.
`define GS_OFF_CTRL 8'h00
`define GS_OFF_STATUS 8'h04
`define GS_OFF_MASK 8'h08
`define GS_OFF_STATE 8'h0C
`define GS_OFF_ALARM 8'h10

// Control register fields and reset value.
`define GS_CTRL_DIN_EN 0
`define GS_CTRL_ONLOAD_EN 1
`define GS_CTRL_W 2
`define GS_CTRL_RST 2'h3

// Event bits, shared by the status and mask registers.
`define GS_EVT_MODE 0
`define GS_EVT_GEN_CLOSED 1
`define GS_EVT_GEN_OPENED 2
`define GS_EVT_UTIL_CLOSED 3
`define GS_EVT_ALARM 4
`define GS_EVT_W 5
`define GS_MASK_RST 5'h00

// Field positions in the state register.
`define GS_ST_PEND 0
`define GS_ST_MODE 1
`define GS_ST_SEQ 2
`define GS_ST_PLANT 5

`endif

/* src/genset_pkg.sv */
`include "genset_cfg.svh"

package genset_pkg;

    // Operating modes; exactly one is held at any time.
    typedef enum logic {
        MODE_HALT = 1'b0,
        MODE_HAND = 1'b1
    } mode_t;

    // Sequencer states, Gray coded along start and load; SEQ_ON_LOAD to SEQ_RAMP and SEQ_RAMP to SEQ_RUN_OFF flip two bits.
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_CRANK = 3'b001,
        SEQ_RUN_OFF = 3'b011,
        SEQ_SYNC = 3'b010,
        SEQ_ON_LOAD = 3'b110,
        SEQ_USYNC = 3'b111,
        SEQ_RAMP = 3'b101
    } seq_t;

    // Front-panel push buttons, one bit per button.
    typedef struct packed {
        logic halt;
        logic hand;
        logic start;
        logic load_to_genset_button;
        logic load_to_utility_button;
    } button_t;

    // Commands to the engine, governor and breakers.
    typedef struct packed {
        logic fuel;
        logic crank;
        logic sync;
        logic ramp;
        logic gen_close;
        logic util_close;
    } plant_t;

    // Sticky update where a set in the clearing cycle wins.
    function automatic logic [`GS_EVT_W-1:0] sticky_upd(
        input logic [`GS_EVT_W-1:0] old,
        input logic [`GS_EVT_W-1:0] set,
        input logic [`GS_EVT_W-1:0] clr);
        return (old & ~clr) | set;
    endfunction : sticky_upd

endpackage : genset_pkg

/* src/edge_detect.sv */
`timescale 1ns/1ns

module edge_detect #(
    parameter int W = 8
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);

    logic [W-1:0] prev;
    logic [W-1:0] next_prev;

    // The previous level only advances on enabled cycles.
    always_comb begin
        next_prev = ce ? level : prev;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prev <= '0;
        end else begin
            prev <= next_prev;
        end
    end

    // A button held through reset is seen as one press when reset releases.
    assign rise = level & ~prev;
    assign fall = ~level & prev;

endmodule : edge_detect

/* src/alarm_latch.sv */
`timescale 1ns/1ns

module alarm_latch #(
    parameter int W = 8
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [W-1:0] cond,
    input wire logic clear_stale,
    output logic [W-1:0] latched,
    output logic [W-1:0] fresh
);

    logic [W-1:0] next_latched;

    // A stale alarm drops on a clear; a present condition always stays.
    always_comb begin
        next_latched = latched;
        if (ce) begin
            next_latched = (latched & (clear_stale ? cond : '1)) | cond;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            latched <= '0;
        end else begin
            latched <= next_latched;
        end
    end

    // Conditions that are about to latch for the first time.
    assign fresh = cond & ~latched;

endmodule : alarm_latch

/* sim/genset_plant_model.sv */
`timescale 1ns/1ns

module genset_plant_model
    import genset_pkg::*;
#(
    parameter int DLY = 4
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire plant_t plant,
    input wire logic stall,
    output logic engine_running,
    output logic in_sync,
    output logic ramp_done
);
    int eng_cnt;
    int syn_cnt;
    int rmp_cnt;

    // Each feedback counts how long its command has stood.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            eng_cnt <= 0;
            syn_cnt <= 0;
            rmp_cnt <= 0;
        end else begin
            eng_cnt <= plant.fuel ? eng_cnt + 1 : 0;
            syn_cnt <= plant.sync ? syn_cnt + 1 : 0;
            rmp_cnt <= plant.ramp ? rmp_cnt + 1 : 0;
        end
    end

    // Stall holds back sync and ramp so an abort can catch them midway.
    assign engine_running = eng_cnt >= DLY;
    assign in_sync = !stall && syn_cnt >= DLY;
    assign ramp_done = !stall && rmp_cnt >= DLY;
endmodule : genset_plant_model

/* sim/genset_mode_sequencer_assertions.sv */
`timescale 1ns/1ns

module genset_mode_sequencer_assertions
    import genset_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire button_t button,
    input wire logic engine_running,
    input wire logic in_sync,
    input wire logic ramp_done,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire plant_t plant
);
    logic [4:0] prev;
    logic [4:0] press;
    logic in_halt;
    logic next_in_halt;

    // Mode is tracked from press edges; halt wins when pressed with hand.
    // A press made and released while the block is frozen is not a press at all.
    always_comb begin
        press = ce ? (button & ~prev) : 5'h00;
        next_in_halt = press[4] ? 1'b1 : (press[3] ? 1'b0 : in_halt);
    end

    // Registers the button levels and the tracked mode.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prev <= 5'h00;
            in_halt <= 1'b1;
        end else if (ce) begin
            prev <= button;
            in_halt <= next_in_halt;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_gen_then_util;
        ##1 !plant.gen_close ##1 plant.util_close;
    endsequence

    chk_halt_cuts_fuel: assert property (
        press[4] |=> !plant.fuel && !plant.crank && !plant.gen_close)
        else $error("halt press left fuel, crank or breaker on");
    chk_halt_util_order: assert property (
        press[4] && engine_running |-> s_gen_then_util)
        else $error("halt did not open generator then close utility");
    chk_halt_no_start: assert property (
        in_halt && $past(in_halt) |-> !plant.fuel && !plant.sync)
        else $error("engine commanded while in halt");
    chk_hand_start: assert property (
        !in_halt && press == 5'h04 && !plant.fuel
        |=> plant.fuel && plant.crank && !plant.gen_close)
        else $error("start press did not crank off load");
    chk_gen_close_sync: assert property (
        $rose(plant.gen_close) |-> $past(in_sync) || !$past(plant.util_close))
        else $error("generator closed without synchronism");
    chk_gen_open_ramp: assert property (
        $fell(plant.gen_close)
        |-> $past(press[4]) || $past(plant.ramp && ramp_done))
        else $error("generator opened before ramp finished");
    chk_sync_to_util: assert property (
        plant.sync && plant.gen_close && in_sync && press == 5'h00
        |=> plant.util_close && plant.ramp && !plant.sync)
        else $error("utility not closed once in sync");
    chk_bus_one_wait: assert property (
        (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle after request");
endmodule : genset_mode_sequencer_assertions

bind genset_mode_sequencer genset_mode_sequencer_assertions i_chk (
    .clk_sys, .rstn, .ce, .button, .engine_running, .in_sync, .ramp_done,
    .avs_read, .avs_write, .avs_waitrequest, .plant);

/* sim/genset_mode_sequencer_test.sv */
`timescale 1ns/1ns

module genset_mode_sequencer_test
    import genset_pkg::*;
;
    localparam int SYNC = 3;
    localparam int RAMP = 2;
    localparam int GEN = 1;
    localparam int UTIL = 0;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] btn = 5'h00;
    logic din_to_genset = 1'b0;
    logic din_to_utility = 1'b0;
    logic on_load_in = 1'b0;
    logic stall = 1'b0;
    logic ce = 1'b1;
    logic [7:0] alarm_cond = 8'h00;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic engine_running, in_sync, ramp_done, irq;
    plant_t plant;
    int num_errors = 0;
    int num_checks = 0;

    genset_mode_sequencer i_genset_mode_sequencer (.clk_sys, .rstn,
        .ce, .button(button_t'(btn)), .din_to_genset, .din_to_utility,
        .on_load_in, .engine_running, .in_sync, .ramp_done, .alarm_cond,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .plant, .irq);
    genset_plant_model i_genset_plant_model (.clk_sys, .rstn, .plant,
        .stall, .engine_running, .in_sync, .ramp_done);

    // Free-running 250 MHz system clock.
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Holds the request until waitrequest is sampled low at an edge.
    task automatic bus(input logic wr, input logic [7:0] adr,
                       input logic [31:0] wd, output logic [31:0] rd);
        bit ok;
        ok = 1'b0;
        @(posedge clk_sys);
        avs_address <= adr;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        for (int i = 0; i < 20 && !ok; i++) begin
            @(posedge clk_sys);
            ok = (avs_waitrequest === 1'b0);
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (!ok) begin
            check("bus answer", 32'h0, 32'h1);
            close_out();
        end
    endtask : bus

    task automatic rd_chk(input string what, input logic [7:0] adr,
                          input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, adr, 32'h0, d);
        check(what, d, exp);
    endtask : rd_chk

    // One-cycle pulse on the digital transfer inputs and the buttons.
    task automatic press(input logic [6:0] m);
        @(posedge clk_sys);
        {din_to_genset, din_to_utility, btn} <= m;
        @(posedge clk_sys);
        {din_to_genset, din_to_utility, btn} <= 7'h00;
    endtask : press

    task automatic chk_pl(input logic [5:0] e);
        check("plant", {26'h0, plant}, {26'h0, e});
    endtask : chk_pl

    // Bounded wait for one plant bit; running out ends the run.
    task automatic wait_pl(input int idx, input logic v);
        int i;
        logic [5:0] pl;
        pl = plant;
        for (i = 0; i < 200 && pl[idx] !== v; i++) begin
            @(posedge clk_sys);
            pl = plant;
        end
        check("plant bit", {31'h0, pl[idx]}, {31'h0, v});
        if (i == 200) begin
            close_out();
        end
    endtask : wait_pl

    task automatic do_reset();
        rstn <= 1'b0;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
    endtask : do_reset

    task automatic hand_start();
        press(7'h08);
        press(7'h04);
        wait_pl(4, 1'b1);
        wait_pl(4, 1'b0);
    endtask : hand_start

    initial begin
        logic [31:0] d;
        do_reset();
        rd_chk("ctrl", 8'h00, 32'h3);
        rd_chk("mask", 8'h08, 32'h0);
        rd_chk("unmapped", 8'h14, 32'h0);
        press(7'h04);
        repeat (8) @(posedge clk_sys);
        chk_pl(6'h00);
        bus(1'b1, 8'h08, 32'h1, d);
        hand_start();
        check("irq", {31'h0, irq}, 32'h1);
        rd_chk("status", 8'h04, 32'h1);
        @(posedge clk_sys);
        check("irq", {31'h0, irq}, 32'h0);
        rd_chk("state", 8'h0C, 32'h0000040E);
        bus(1'b1, 8'h08, 32'h0, d);
        $display("test start and interrupt done");
        press(7'h01);
        wait_pl(UTIL, 1'b1);
        stall <= 1'b1;
        press(7'h02);
        wait_pl(SYNC, 1'b1);
        chk_pl(6'h29);
        press(7'h08);
        wait_pl(SYNC, 1'b0);
        chk_pl(6'h21);
        stall <= 1'b0;
        press(7'h02);
        wait_pl(GEN, 1'b1);
        press(7'h01);
        wait_pl(RAMP, 1'b1);
        chk_pl(6'h27);
        wait_pl(GEN, 1'b0);
        on_load_in <= 1'b1;
        wait_pl(GEN, 1'b1);
        on_load_in <= 1'b0;
        wait_pl(RAMP, 1'b1);
        wait_pl(GEN, 1'b0);
        press(7'h40);
        wait_pl(GEN, 1'b1);
        press(7'h20);
        wait_pl(GEN, 1'b0);
        check("irq masked", {31'h0, irq}, 32'h0);
        bus(1'b1, 8'h00, 32'h0, d);
        press(7'h40);
        on_load_in <= 1'b1;
        ce <= 1'b0;
        press(7'h10);
        ce <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk_pl(6'h21);
        on_load_in <= 1'b0;
        rd_chk("ctrl", 8'h00, 32'h0);
        $display("test transfers done");
        do_reset();
        hand_start();
        alarm_cond <= 8'h03;
        press(7'h40);
        wait_pl(GEN, 1'b1);
        press(7'h20);
        wait_pl(UTIL, 1'b1);
        wait_pl(GEN, 1'b0);
        press(7'h40);
        wait_pl(GEN, 1'b1);
        alarm_cond <= 8'h02;
        rd_chk("alarm", 8'h10, 32'h3);
        press(7'h10);
        wait_pl(GEN, 1'b0);
        wait_pl(UTIL, 1'b1);
        chk_pl(6'h01);
        rd_chk("alarm", 8'h10, 32'h2);
        rd_chk("status", 8'h04, 32'h1F);
        press(7'h04);
        on_load_in <= 1'b1;
        press(7'h02);
        repeat (8) @(posedge clk_sys);
        chk_pl(6'h01);
        $display("test halt done");
        close_out();
    end
endmodule : genset_mode_sequencer_test
